// *** acr_align.sv ***
// Resolution masking and alignment of each regular conversion result that is loaded.
// Assumes the raw sample holds its bits in the low end.
`timescale 1ns/1ps
module acr_align
  import acr_pkg::*;
(
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic srst,
  // Result link.
  acr_res_if.fmt    link
);
  typedef struct packed {
    logic [15:0] data;
  } acr_align_state_t;

  acr_align_state_t q;
  acr_align_state_t next_q;

  // Masks the sample to its width and places it right or left.
  function automatic logic [15:0] format(input logic [1:0] res,
                                         input logic left,
                                         input logic [11:0] raw);
    logic [11:0] mask;
    logic [3:0]  shift;
    mask  = 12'hfff;
    shift = 4'h4;
    unique case (acr_res_t'(res))
      ACR_RES_12: begin mask = 12'hfff; shift = 4'h4; end
      ACR_RES_10: begin mask = 12'h3ff; shift = 4'h6; end
      ACR_RES_8:  begin mask = 12'h0ff; shift = 4'h8; end
      ACR_RES_6:  begin mask = 12'h03f; shift = 4'ha; end
    endcase
    if (left) begin
      return {4'h0, raw & mask} << shift;
    end
    return {4'h0, raw & mask};
  endfunction

  // The data word changes only when a result is loaded.
  always_comb begin
    next_q = q;
    if (link.load) begin
      next_q.data = format(link.res, link.left, link.raw);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign link.data = q.data;
endmodule

// *** acr_pkg.sv ***
// Shared constants and types for the converter configuration block.
// Assumes a single ref_clk domain and a 32-bit register port.
package acr_pkg;

  // Register map.
  localparam logic [7:0]  ACR_CFG_OFFSET = 8'h0c;
  localparam logic [31:0] ACR_CFG_RESET  = 32'h00000000;

  // Field positions inside the configuration word.
  localparam int ACR_WDCH_LSB     = 26;
  localparam int ACR_AUTOINJ_BIT  = 25;
  localparam int ACR_INJ_WD_BIT   = 24;
  localparam int ACR_REG_WD_BIT   = 23;
  localparam int ACR_SGL_BIT      = 22;
  localparam int ACR_QUEUE_BIT    = 21;
  localparam int ACR_INJ_DISC_BIT = 20;
  localparam int ACR_DCNT_LSB     = 17;
  localparam int ACR_REG_DISC_BIT = 16;
  localparam int ACR_DELAY_BIT    = 14;
  localparam int ACR_REPEAT_BIT   = 13;
  localparam int ACR_OVR_BIT      = 12;
  localparam int ACR_EDGE_LSB     = 10;
  localparam int ACR_SRC_LSB      = 6;
  localparam int ACR_ALIGN_BIT    = 5;
  localparam int ACR_RES_LSB      = 3;
  localparam int ACR_CIRC_BIT     = 1;
  localparam int ACR_XFER_BIT     = 0;

  // Writable fields grouped by the start flags that lock them.
  localparam logic [31:0] ACR_WMASK_BOTH = 32'h7e40403b;
  localparam logic [31:0] ACR_WMASK_REG  = 32'h008f3fc0;
  localparam logic [31:0] ACR_WMASK_INJ  = 32'h01300000;
  // Fields mirrored from the master converter in paired mode.
  localparam logic [31:0] ACR_SLAVE_MASK = 32'h023f6000;

  // Legal watchdog channel codes.
  localparam logic [4:0] ACR_CH_MIN = 5'h01;
  localparam logic [4:0] ACR_CH_MAX = 5'h12;

  // Values after reset of derived outputs.
  localparam logic       ACR_INJ_TRIG_EN_RST = 1'b1;
  localparam logic [3:0] ACR_DISC_COUNT_RST  = 4'h1;

  typedef enum logic [1:0] {
    ACR_EDGE_OFF  = 2'b00,
    ACR_EDGE_RISE = 2'b01,
    ACR_EDGE_FALL = 2'b10,
    ACR_EDGE_BOTH = 2'b11
  } acr_edge_t;

  typedef enum logic [1:0] {
    ACR_RES_12 = 2'b00,
    ACR_RES_10 = 2'b01,
    ACR_RES_8  = 2'b10,
    ACR_RES_6  = 2'b11
  } acr_res_t;

endpackage

// *** acr_res_if.sv ***
// Result formatting link between the control logic and the aligner.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ps
interface acr_res_if;
  logic [1:0]  res;
  logic        left;
  logic        load;
  logic [11:0] raw;
  logic [15:0] data;
  modport ctrl (output res, output left, output load, output raw,
                input data);
  modport fmt  (input res, input left, input load, input raw,
                output data);
endinterface

// *** acr_sync.sv ***
// Three-stage synchroniser for the external trigger event lines.
// Assumes the lines are asynchronous to ref_clk.
`timescale 1ns/1ps
module acr_sync #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             srst,
  // Lines.
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } acr_sync_state_t;

  acr_sync_state_t q;
  acr_sync_state_t next_q;

  // A level is accepted only once the second and third stages agree.
  always_comb begin
    next_q        = q;
    next_q.s1     = pin_in;
    next_q.s2     = q.s1;
    next_q.s3     = q.s2;
    next_q.stable = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.stable);
  end

  // All stages clear on reset.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign level_out = q.stable;
endmodule

// *** acr_top.sv ***
// Converter configuration register and the control decode behind it.
// Assumes the start flags and conversion events come from logic on
// ref_clk, and trigger event lines come from pins.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module acr_top
  import acr_pkg::*;
#(
  parameter int EVENTS = 16
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Register port.
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Group activity flags.
  input  wire logic        regular_start_flag,
  input  wire logic        injected_start_flag,
  // Paired converter.
  input  wire logic        paired_mode_on,
  input  wire logic [31:0] master_cfg,
  // External trigger events.
  input  wire logic [15:0] trig_event_pin,
  // Conversion events.
  input  wire logic        conv_valid,
  input  wire logic        conv_injected,
  input  wire logic [4:0]  conv_channel,
  input  wire logic [11:0] conv_raw,
  input  wire logic        overrun_seen,
  input  wire logic        regular_group_done,
  input  wire logic        queue_empty,
  // Control outputs.
  output logic             regular_trigger,
  output logic             watchdog_check,
  output logic             auto_inject_start,
  output logic             injected_trigger_enable,
  output logic             disc_regular_on,
  output logic             disc_injected_on,
  output logic      [3:0]  disc_channel_count,
  output logic             repeat_on,
  output logic             delay_on,
  output logic             software_trigger_only,
  output logic             result_load,
  output logic      [15:0] result_data,
  output logic             transfer_request_on,
  output logic             transfer_mode_circular
);
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] eff;
    logic [31:0] rdata;
    logic        trig_prev;
    logic        reg_trig;
    logic        wd_check;
    logic        auto_inj;
    logic        inj_trig_en;
    logic        res_load;
    logic [3:0]  disc_count;
    logic        xfer_on;
    logic        xfer_circ;
    logic        sw_only;
  } acr_top_state_t;

  localparam acr_top_state_t RESET_STATE = '{
    cfg:         ACR_CFG_RESET,
    eff:         ACR_CFG_RESET,
    rdata:       '0,
    trig_prev:   1'b0,
    reg_trig:    1'b0,
    wd_check:    1'b0,
    auto_inj:    1'b0,
    inj_trig_en: ACR_INJ_TRIG_EN_RST,
    res_load:    1'b0,
    disc_count:  ACR_DISC_COUNT_RST,
    xfer_on:     1'b0,
    xfer_circ:   1'b0,
    sw_only:     (ACR_CFG_RESET[ACR_EDGE_LSB +: 2] == 2'b00)
  };

  acr_top_state_t q;
  acr_top_state_t next_q;

  logic [15:0] trig_level;
  logic [31:0] eff_cfg;
  logic [31:0] wmask;
  logic        cfg_hit;
  logic        trig_now;
  logic        edge_seen;
  logic        wd_group_on;
  logic        wd_chan_ok;
  logic        load_now;
  acr_edge_t   edge_mode;

  acr_res_if res_link ();

  // Trigger lines arrive from pins and need a full crossing.
  acr_sync #(
    .WIDTH (EVENTS)
  ) u_sync (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .pin_in    (trig_event_pin),
    .level_out (trig_level)
  );

  acr_align u_align (
    .ref_clk (ref_clk),
    .srst    (srst),
    .link    (res_link)
  );

  // True for channel codes that name a real input.
  function automatic logic chan_legal(input logic [4:0] ch);
    return (ch >= ACR_CH_MIN) && (ch <= ACR_CH_MAX);
  endfunction

  // Write mask: each field is writable only while its groups are idle,
  // and mirrored fields of a slave are never writable.
  function automatic logic [31:0] lock_mask(input logic reg_busy,
                                            input logic inj_busy,
                                            input logic paired);
    logic [31:0] m;
    m = '0;
    if (!reg_busy && !inj_busy) begin
      m = m | ACR_WMASK_BOTH;
    end
    if (!reg_busy) begin
      m = m | ACR_WMASK_REG;
    end
    if (!inj_busy) begin
      m = m | ACR_WMASK_INJ;
    end
    if (paired) begin
      m = m & ~ACR_SLAVE_MASK;
    end
    return m;
  endfunction

  // The value seen by software and by the control logic alike.
  assign eff_cfg = paired_mode_on ?
                   ((q.cfg & ~ACR_SLAVE_MASK) |
                    (master_cfg & ACR_SLAVE_MASK)) : q.cfg;
  assign cfg_hit = (reg_addr == ACR_CFG_OFFSET);
  assign wmask   = lock_mask(regular_start_flag, injected_start_flag,
                             paired_mode_on);

  // Trigger edge qualification on the selected event.
  assign edge_mode = acr_edge_t'(eff_cfg[ACR_EDGE_LSB +: 2]);
  assign trig_now  = trig_level[eff_cfg[ACR_SRC_LSB +: 4]];
  always_comb begin
    edge_seen = 1'b0;
    unique case (edge_mode)
      ACR_EDGE_OFF:  edge_seen = 1'b0;
      ACR_EDGE_RISE: edge_seen = trig_now && !q.trig_prev;
      ACR_EDGE_FALL: edge_seen = !trig_now && q.trig_prev;
      ACR_EDGE_BOTH: edge_seen = trig_now != q.trig_prev;
    endcase
  end

  // Watchdog qualification for the conversion in flight.
  assign wd_group_on = conv_injected ? eff_cfg[ACR_INJ_WD_BIT]
                                     : eff_cfg[ACR_REG_WD_BIT];
  assign wd_chan_ok  = !eff_cfg[ACR_SGL_BIT] ||
                       (chan_legal(eff_cfg[ACR_WDCH_LSB +: 5]) &&
                        (conv_channel ==
                         eff_cfg[ACR_WDCH_LSB +: 5]));

  // Regular results load unless an overrun keeps the old one.
  assign load_now = conv_valid && !conv_injected &&
                    (!overrun_seen || eff_cfg[ACR_OVR_BIT]);

  assign res_link.res  = eff_cfg[ACR_RES_LSB +: 2];
  assign res_link.left = eff_cfg[ACR_ALIGN_BIT];
  assign res_link.load = load_now;
  assign res_link.raw  = conv_raw;

  // Next state; reserved bits stay at reset since no mask covers them.
  always_comb begin
    next_q = q;
    if (reg_wr && cfg_hit) begin
      next_q.cfg = (q.cfg & ~wmask) | (reg_wdata & wmask);
    end
    next_q.eff         = eff_cfg;
    next_q.rdata       = (reg_rd && cfg_hit) ? eff_cfg : '0;
    next_q.trig_prev   = trig_now;
    // A trigger only counts while regular conversions are armed.
    next_q.reg_trig    = regular_start_flag && edge_seen;
    next_q.wd_check    = conv_valid && wd_group_on && wd_chan_ok;
    next_q.auto_inj    = regular_group_done &&
                         eff_cfg[ACR_AUTOINJ_BIT];
    next_q.inj_trig_en = !(eff_cfg[ACR_QUEUE_BIT] && queue_empty);
    next_q.res_load    = load_now;
    next_q.disc_count  = {1'b0, eff_cfg[ACR_DCNT_LSB +: 3]} + 4'h1;
    // Paired operation hands transfer control to the common register.
    next_q.xfer_on     = !paired_mode_on && eff_cfg[ACR_XFER_BIT];
    next_q.xfer_circ   = !paired_mode_on && eff_cfg[ACR_XFER_BIT] &&
                         eff_cfg[ACR_CIRC_BIT];
    next_q.sw_only     = (edge_mode == ACR_EDGE_OFF);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= RESET_STATE;
    end else begin
      q <= next_q;
    end
  end

  // Outputs come straight from the state register, result_data from the aligner's register.
  assign reg_rdata               = q.rdata;
  assign regular_trigger         = q.reg_trig;
  assign watchdog_check          = q.wd_check;
  assign auto_inject_start       = q.auto_inj;
  assign injected_trigger_enable = q.inj_trig_en;
  assign disc_regular_on         = q.eff[ACR_REG_DISC_BIT];
  assign disc_injected_on        = q.eff[ACR_INJ_DISC_BIT];
  assign disc_channel_count      = q.disc_count;
  assign repeat_on               = q.eff[ACR_REPEAT_BIT];
  assign delay_on                = q.eff[ACR_DELAY_BIT];
  assign software_trigger_only   = q.sw_only;
  assign result_load             = q.res_load;
  assign result_data             = res_link.data;
  assign transfer_request_on     = q.xfer_on;
  assign transfer_mode_circular  = q.xfer_circ;

  // Helpers that only the checks below read.
  logic [31:0] cfg_both;
  logic [31:0] cfg_reg;
  logic [31:0] cfg_slave;
  logic        auto_bit;
  logic [2:0]  dcnt_field;
  assign cfg_both   = q.cfg & ACR_WMASK_BOTH;
  assign cfg_reg    = q.cfg & ACR_WMASK_REG;
  assign cfg_slave  = q.cfg & ACR_SLAVE_MASK;
  assign auto_bit   = eff_cfg[ACR_AUTOINJ_BIT];
  assign dcnt_field = eff_cfg[ACR_DCNT_LSB +: 3];

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  property p_wd_reserved;
    conv_valid && eff_cfg[ACR_SGL_BIT] &&
      !chan_legal(eff_cfg[ACR_WDCH_LSB +: 5]) |=> !watchdog_check;
  endproperty
  a_wd_reserved: assert property (p_wd_reserved)
    else $error("Watchdog matched a reserved channel code.");

  property p_lock_both;
    reg_wr && cfg_hit && (regular_start_flag || injected_start_flag)
      |=> cfg_both == $past(cfg_both);
  endproperty
  a_lock_both: assert property (p_lock_both)
    else $error("Common field changed while a group was active.");

  property p_lock_reg;
    reg_wr && cfg_hit && regular_start_flag |=> cfg_reg == $past(cfg_reg);
  endproperty
  a_lock_reg: assert property (p_lock_reg)
    else $error("Regular field changed while regular group active.");

  property p_auto_inj;
    regular_group_done |=> auto_inject_start == $past(auto_bit);
  endproperty
  a_auto_inj: assert property (p_auto_inj)
    else $error("Auto-injection start did not follow the enable.");

  property p_paired_read;
    reg_rd && cfg_hit && paired_mode_on
      |=> (reg_rdata & ACR_SLAVE_MASK) ==
          ($past(master_cfg) & ACR_SLAVE_MASK);
  endproperty
  a_paired_read: assert property (p_paired_read)
    else $error("Slave read did not return the master fields.");

  property p_paired_hold;
    paired_mode_on && reg_wr && cfg_hit |=> cfg_slave == $past(cfg_slave);
  endproperty
  a_paired_hold: assert property (p_paired_hold)
    else $error("Mirrored field was written in paired mode.");

  property p_wd_group;
    conv_valid && conv_injected && !eff_cfg[ACR_INJ_WD_BIT]
      |=> !watchdog_check;
  endproperty
  a_wd_group: assert property (p_wd_group)
    else $error("Injected conversion checked with watchdog off.");

  property p_queue;
    queue_empty && eff_cfg[ACR_QUEUE_BIT] |=> !injected_trigger_enable;
  endproperty
  a_queue: assert property (p_queue)
    else $error("Injected triggers stayed on with an empty queue.");

  property p_disc;
    1'b1 |=> disc_channel_count == {1'b0, $past(dcnt_field)} + 4'h1;
  endproperty
  a_disc: assert property (p_disc)
    else $error("Discontinuous count is not the field plus one.");

  property p_overrun;
    conv_valid && !conv_injected && overrun_seen && !eff_cfg[ACR_OVR_BIT]
      |=> !result_load && $stable(result_data);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("Result replaced on overrun in keep mode.");

  property p_edge_off;
    edge_mode == ACR_EDGE_OFF |=> !regular_trigger;
  endproperty
  a_edge_off: assert property (p_edge_off)
    else $error("Hardware trigger seen with detection disabled.");

  property p_xfer;
    paired_mode_on |=> !transfer_request_on && !transfer_mode_circular;
  endproperty
  a_xfer: assert property (p_xfer)
    else $error("Transfer bits acted in paired mode.");

  property p_reserved;
    !reg_rdata[31] && !reg_rdata[15] && !reg_rdata[2];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved bit read back as one.");

  cover property (regular_trigger);
  cover property (auto_inject_start ##1 regular_trigger [*2]);
  cover property (conv_valid && overrun_seen ##1 result_load);
  cover property (watchdog_check && paired_mode_on);
endmodule

// *** testbench.sv ***
// Self-checking bench for the converter configuration block.
// Assumes acr_pkg and acr_top are compiled first; one ref_clk domain.
`timescale 1ns/1ps
module testbench;
  import acr_pkg::*;
  // Design inputs.
  logic        ref_clk, srst, reg_wr, reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, master_cfg;
  logic        regular_start_flag, injected_start_flag, paired_mode_on;
  logic [15:0] trig_event_pin;
  logic        conv_valid, conv_injected, overrun_seen;
  logic [4:0]  conv_channel;
  logic [11:0] conv_raw;
  logic        regular_group_done, queue_empty;
  // Design outputs.
  logic [31:0] reg_rdata;
  logic        regular_trigger, watchdog_check, auto_inject_start;
  logic        injected_trigger_enable, disc_regular_on, disc_injected_on;
  logic [3:0]  disc_channel_count;
  logic        repeat_on, delay_on, software_trigger_only, result_load;
  logic [15:0] result_data;
  logic        transfer_request_on, transfer_mode_circular;
  // Bench state; model is the word that software expects to read back.
  int          errors, n_checks, cycles, n;
  logic [31:0] model, rd, w;
  logic [4:0]  ch;
  localparam logic [31:0] FULL = 32'h7dff5ffb;
  localparam logic [4:0]  CHS [4] = '{5'h00, 5'h05, 5'h12, 5'h13};

  acr_top #(.EVENTS(16)) acr_top_inst (
    .ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .regular_start_flag, .injected_start_flag, .paired_mode_on,
    .master_cfg, .trig_event_pin, .conv_valid, .conv_injected,
    .conv_channel, .conv_raw, .overrun_seen, .regular_group_done,
    .queue_empty, .regular_trigger, .watchdog_check, .auto_inject_start,
    .injected_trigger_enable, .disc_regular_on, .disc_injected_on,
    .disc_channel_count, .repeat_on, .delay_on, .software_trigger_only,
    .result_load, .result_data, .transfer_request_on,
    .transfer_mode_circular
  );

  // Free-running 250 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Hang guard; the tests need about 3700 cycles.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors = errors + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("TB: %0d checks, %0d errors", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe; the slave never stalls.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe.
  task automatic rdreg(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  // Writes the word and predicts which fields the flags let through.
  task automatic cfg(input logic [31:0] d);
    logic [31:0] m;
    // The mask uses the flags as the design saw them at the write edge.
    wr(ACR_CFG_OFFSET, d);
    m = (regular_start_flag ? 32'h0 : ACR_WMASK_REG)
      | (injected_start_flag ? 32'h0 : ACR_WMASK_INJ)
      | ((regular_start_flag | injected_start_flag) ?
         32'h0 : ACR_WMASK_BOTH);
    if (paired_mode_on) m = m & ~ACR_SLAVE_MASK;
    model = (model & ~m) | (d & m);
    @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [31:0] eff();
    if (!paired_mode_on) return model;
    return (model & ~ACR_SLAVE_MASK) | (master_cfg & ACR_SLAVE_MASK);
  endfunction

  task automatic check_cfg();
    rdreg(ACR_CFG_OFFSET);
    check_val(rd, eff());
  endtask

  task automatic levels(input logic [31:0] v);
    check_val(disc_regular_on, v[16]);
    check_val(disc_injected_on, v[20]);
    check_val(disc_channel_count, v[19:17] + 4'h1);
    check_val(repeat_on, v[13]);
    check_val(delay_on, v[14]);
    check_val(software_trigger_only, v[11:10] == 2'b00);
    check_val(transfer_request_on, v[0] & !paired_mode_on);
    check_val(transfer_mode_circular,
              v[1] & v[0] & !paired_mode_on);
  endtask

  task automatic conv(input logic inj, input logic [4:0] c,
                      input logic [11:0] raw, input logic ovr);
    @(posedge ref_clk);
    conv_valid    <= 1'b1;
    conv_injected <= inj;
    conv_channel  <= c;
    conv_raw      <= raw;
    overrun_seen  <= ovr;
    @(posedge ref_clk);
    conv_valid <= 1'b0;
    #1;
  endtask

  // Expected result word: mask to the resolution, then place it.
  function automatic logic [15:0] fmt(input logic [1:0] r, input logic l,
                                      input logic [11:0] x);
    int          b;
    logic [15:0] m;
    b = 12 - 2 * r;
    m = x & ((16'h1 << b) - 16'h1);
    return l ? m << (16 - b) : m;
  endfunction

  // Counts trigger pulses after one pin change; sync takes about 5 cycles.
  task automatic pin_count(input int p, input logic v, output int c);
    @(posedge ref_clk);
    trig_event_pin[p] <= v;
    c = 0;
    repeat (10) begin
      @(posedge ref_clk);
      #1;
      if (regular_trigger === 1'b1) c = c + 1;
    end
  endtask

  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, master_cfg} = '0;
    {regular_start_flag, injected_start_flag, paired_mode_on} = '0;
    {trig_event_pin, conv_valid, conv_injected, overrun_seen} = '0;
    {conv_channel, conv_raw, regular_group_done, queue_empty} = '0;
    srst = 1'b1;
    model = ACR_CFG_RESET;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    // Reset values, and read data falling back to zero.
    check_cfg();
    check_val(injected_trigger_enable, 1'b1);
    levels(32'h0);
    @(posedge ref_clk);
    #1 check_val(reg_rdata, 32'h0);
    // Reserved bits, unmapped address.
    cfg(32'hfdffdfff);
    check_val(model, FULL);
    check_cfg();
    wr(8'h10, 32'h0);
    rdreg(8'h10);
    check_val(rd, 32'h0);
    check_cfg();
    $display("TB: reset and map test done");
    // Level decode over varied words, keeping software's mode rules.
    for (int k = 0; k < 8; k++) begin
      w = (32'h9e3779b9 * (k + 1)) & FULL;
      if (w[25]) w = w & ~32'h00110000;
      if (w[16]) w[13] = 1'b0;
      w[19:17] = k[2:0];
      cfg(w);
      check_cfg();
      levels(model);
    end
    $display("TB: level decode test done");
    // Field locks under every flag pair, alternating full and empty data.
    for (int k = 0; k < 8; k++) begin
      @(posedge ref_clk);
      regular_start_flag  <= k[1];
      injected_start_flag <= k[2];
      @(posedge ref_clk);
      cfg(k[0] ? 32'h0 : FULL);
      check_cfg();
    end
    @(posedge ref_clk);
    {regular_start_flag, injected_start_flag} <= 2'b00;
    $display("TB: lock test done");
    // Paired mode: mirrored fields, dropped writes, ignored transfer bits.
    cfg(FULL);
    @(posedge ref_clk);
    paired_mode_on <= 1'b1;
    master_cfg     <= 32'h5a4aa5a5;
    repeat (2) @(posedge ref_clk);
    #1 check_cfg();
    levels(eff());
    cfg(32'h0);
    check_cfg();
    @(posedge ref_clk);
    paired_mode_on <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check_cfg();
    $display("TB: paired test done");
    // Result format and overrun policy over all resolutions.
    for (int k = 0; k < 8; k++) begin
      w = 32'h0;
      w[5] = k[2];
      w[4:3] = k[1:0];
      w[12] = k[0];
      cfg(w);
      conv(1'b0, 5'h03, 12'hb6d, 1'b0);
      check_val(result_load, 1'b1);
      check_val(result_data, fmt(k[1:0], k[2], 12'hb6d));
      conv(1'b0, 5'h03, 12'h4d2, 1'b1);
      check_val(result_load, k[0]);
      check_val(result_data,
                fmt(k[1:0], k[2], k[0] ? 12'h4d2 : 12'hb6d));
      conv(1'b1, 5'h03, 12'h777, 1'b0);
      check_val(result_load, 1'b0);
    end
    $display("TB: result test done");
    // Watchdog enables, single channel and reserved channel codes.
    for (int k = 0; k < 32; k++) begin
      w = 32'h0;
      w[24:22] = k[2:0];
      w[30:26] = CHS[k[4:3]];
      cfg(w);
      for (int j = 0; j < 4; j++) begin
        ch = j[0] ? w[30:26] : 5'h07;
        conv(j[1], ch, 12'h0, 1'b0);
        check_val(watchdog_check, (j[1] ? w[24] : w[23]) &
                  (!w[22] | (ch == w[30:26] && ch >= 5'h01 &&
                  ch <= 5'h12)));
      end
    end
    $display("TB: watchdog test done");
    // Auto-injection and queue policy.
    for (int k = 0; k < 4; k++) begin
      cfg(k[0] ? 32'h02200000 : 32'h0);
      @(posedge ref_clk);
      regular_group_done <= 1'b1;
      queue_empty        <= k[1];
      @(posedge ref_clk);
      regular_group_done <= 1'b0;
      #1 check_val(auto_inject_start, k[0]);
      @(posedge ref_clk);
      #1 check_val(injected_trigger_enable, !(k[0] & k[1]));
    end
    $display("TB: injection test done");
    // Every edge code with every source; a neighbour pin must not fire.
    for (int k = 0; k < 64; k++) begin
      @(posedge ref_clk);
      regular_start_flag <= 1'b0;
      w = 32'h0;
      w[11:10] = k[1:0];
      w[9:6] = k[5:2];
      cfg(w);
      @(posedge ref_clk);
      regular_start_flag <= 1'b1;
      pin_count(k[5:2] ^ 4'h1, 1'b1, n);
      check_val(n, 0);
      pin_count(k[5:2] ^ 4'h1, 1'b0, n);
      check_val(n, 0);
      pin_count(k[5:2], 1'b1, n);
      check_val(n, k[0]);
      pin_count(k[5:2], 1'b0, n);
      check_val(n, k[1]);
    end
    @(posedge ref_clk);
    regular_start_flag <= 1'b0;
    pin_count(15, 1'b1, n);
    check_val(n, 0);
    $display("TB: trigger test done");
    // Second reset in mid-run.
    cfg(FULL);
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    model = ACR_CFG_RESET;
    check_cfg();
    levels(32'h0);
    check_val(result_data, 16'h0);
    check_val(injected_trigger_enable, 1'b1);
    $display("TB: second reset test done");
    report_and_stop();
  end
endmodule
